/* File: logic/cbr_pkg.sv */
// Constants, register map and state codes for the control line bit receiver
// Behaviour
// - On a valid start bit, set the start flag and raise an interrupt.
// - After byte, end bit and acknowledge, fill buffer, set complete flag, interrupt.
// - Buffer holds 8 data bits, end bit and the acknowledge level seen on line.
// - Keep receiving blocks until one with end bit 1 completes, then idle.
// - On any reception error interrupt, discard data and wait for a start bit.
// - Address register holds one enable bit per logical address.
// - Broadcasts always received; acknowledged with 0 only if address 15 enabled.
// - Filtered level changes only after the configured count of equal samples.
// - High code 10 needs three highs; low code 011 needs four lows.
// - Flag cycle error outside 67/fs or 90/fs, each adjustable -4..+3.
// - Bit value sampled at 34/fs after its falling edge, adjustable -8..+6 in 2/fs steps.
// - Header match always acknowledged; data match only when not disabled.
// - Acknowledge drives line low for about 1.526 ms, starting right after the filtered fall.
// - With suspend set, max cycle and overrun errors are held and give no immediate interrupt.
// - While errors are held, acknowledge is inverted; missing bits end in a timeout.
// - Suspended interrupt raised after the inverted acknowledge or the timeout.
// - Timeout length field matters only while suspension is enabled.
// - Foreign-address reception receives normally but never acknowledges.
// - A new start before the end block gives a max cycle error, then receives.
// - Start valid only with rise and ending fall inside their windows.
// - All sampling and timing runs from a 32.768 kHz sample tick.
package cbr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_HZ = 250_000_000;
  localparam int FS_HZ = 32768;
  localparam int FS_DIV_DEF = CORE_HZ / FS_HZ;
  localparam int ACK_LOW_NS = 1_526_000;
  localparam int ACK_TICKS_INT = int'((64'(ACK_LOW_NS) * FS_HZ) / 1_000_000_000);
  localparam logic [6:0] ACK_TICKS = 7'(ACK_TICKS_INT);
  localparam logic [9:0] CYC_MIN_BASE = 10'h043;
  localparam logic [9:0] CYC_MAX_BASE = 10'h05a;
  localparam logic [9:0] DEC_BASE = 10'h022;
  // One nominal bit cycle, unit of the timeout field
  localparam logic [9:0] TOUT_UNIT = 10'h04f;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_BUFFER = 8'h10;

  // rx_control_one fields
  localparam int C1_SUSPEND = 0;
  localparam int C1_ACKDIS = 1;
  localparam int C1_FOREIGN = 2;
  localparam int C1_HNC_LSB = 3;
  localparam int C1_LNC_LSB = 5;
  localparam int C1_MIN_LSB = 8;
  localparam int C1_MAX_LSB = 11;
  localparam int C1_DEC_LSB = 14;
  localparam int C1_TOUT_LSB = 17;
  localparam int C1_WIDTH = 20;
  localparam logic [C1_WIDTH-1:0] C1_RESET = 20'h00000;
  localparam logic [31:0] C2_RESET = 32'h00000000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // rx_status_reg bit positions
  localparam int ST_END = 0;
  localparam int ST_START = 1;
  localparam int ST_MAX = 2;
  localparam int ST_MIN = 3;
  localparam int ST_ACK = 4;
  localparam int ST_OVR = 5;
  localparam int ST_WAV = 6;
  localparam int ST_WIDTH = 7;

  localparam logic [3:0] BROADCAST_ADDR = 4'hf;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] EOM_BIT = 4'h8;
  localparam logic [3:0] DEST_BIT = 4'h7;

  typedef enum logic [4:0] {
    CBR_IDLE = 5'b00001,
    CBR_START_LOW = 5'b00010,
    CBR_START_HIGH = 5'b00100,
    CBR_BIT = 5'b01000,
    CBR_SKIP = 5'b10000
  } cbr_state_type;

endpackage

/* File: logic/cbr_line_filter.sv */
// Noise filter turning raw line samples into a clean level with edge pulses
`timescale 1ns/1ns
module cbr_line_filter
  import cbr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fs_tick,
  input wire logic line_raw,
  input wire logic [1:0] high_code,
  input wire logic [2:0] low_code,
  output logic level_q,
  output logic fall_q,
  output logic rise_q
);

  logic [3:0] run_q;
  logic [3:0] need;

  // code plus one is the sample count
  assign need = level_q ? ({1'b0, low_code} + 4'h1) : ({2'b00, high_code} + 4'h1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= 1'b1;
      run_q <= 4'h0;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      fall_q <= 1'b0;
      rise_q <= 1'b0;
      if (fs_tick) begin
        if (line_raw == level_q) begin
          run_q <= 4'h0;
        end else if (run_q + 4'h1 >= need) begin
          run_q <= 4'h0;
          level_q <= line_raw;
          fall_q <= level_q;
          rise_q <= !level_q;
        end else begin
          run_q <= run_q + 4'h1;
        end
      end
    end
  end

endmodule // cbr_line_filter

/* File: logic/cbr_receiver.sv */
// Receive path of the single-wire control line with its register slave
`timescale 1ns/1ns
module cbr_receiver
  import cbr_pkg::*;
#(
  parameter int FS_DIV = FS_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cec_line_in,
  output logic cec_line_out,
  output logic cec_line_oe_n,
  output logic irq_pulse
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [12:0] div_q;
  logic fs_tick;
  logic level;
  logic fall;
  logic rise;
  logic [C1_WIDTH-1:0] ctl1_q;
  logic [31:0] ctl2_q;
  logic [15:0] addr_en_q;
  logic [ST_WIDTH-1:0] stat_q;
  logic [9:0] buf_q;
  logic buf_full_q;
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic acc;
  logic rd_stat;
  logic rd_buf;
  cbr_state_type state_q;
  logic [9:0] t_q;
  logic [3:0] bit_q;
  logic [9:0] shift_q;
  logic hdr_q;
  logic match_q;
  logic [ST_WIDTH-1:0] pend_q;
  logic [ST_WIDTH-1:0] flag_set_q;
  logic buf_wr_q;
  logic ack_start_q;
  logic [6:0] ack_cnt_q;
  logic drive_q;
  logic [9:0] cyc_min;
  logic [9:0] cyc_max;
  logic [9:0] dec_pt;
  logic [9:0] tout;
  logic [9:0] sr_early;
  logic [9:0] sr_late;
  logic [9:0] sc_min;
  logic [9:0] sc_max;
  logic suspend;
  logic [3:0] dest;
  logic dest_en;
  logic keep;
  logic want_ack;
  logic pend_any;

  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  // divide core clock to the sample rate
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 13'h0000;
    end else if (div_q == 13'(FS_DIV - 1)) begin
      div_q <= 13'h0000;
    end else begin
      div_q <= div_q + 13'h0001;
    end
  end

  assign fs_tick = (div_q == 13'h0000);

  cbr_line_filter u_filter (
    .core_clk(core_clk),
    .rstn(rstn),
    .fs_tick(fs_tick),
    .line_raw(cec_line_in),
    .high_code(ctl1_q[C1_HNC_LSB +: 2]),
    .low_code(ctl1_q[C1_LNC_LSB +: 3]),
    .level_q(level),
    .fall_q(fall),
    .rise_q(rise)
  );

  // ----------------------------------------------------------------
  // Timing limits
  // ----------------------------------------------------------------
  // signed trim of cycle limits
  assign cyc_min = CYC_MIN_BASE + {{7{ctl1_q[C1_MIN_LSB+2]}}, ctl1_q[C1_MIN_LSB +: 3]};
  assign cyc_max = CYC_MAX_BASE + {{7{ctl1_q[C1_MAX_LSB+2]}}, ctl1_q[C1_MAX_LSB +: 3]};
  // trim in steps of two ticks
  assign dec_pt = DEC_BASE + {{6{ctl1_q[C1_DEC_LSB+2]}}, ctl1_q[C1_DEC_LSB +: 3], 1'b0};
  assign tout = ({7'h00, ctl1_q[C1_TOUT_LSB +: 3]} + 10'h001) * TOUT_UNIT;
  assign sr_early = {2'b00, ctl2_q[7:0]};
  assign sr_late = {2'b00, ctl2_q[15:8]};
  assign sc_min = {2'b00, ctl2_q[23:16]};
  assign sc_max = {2'b00, ctl2_q[31:24]};
  assign suspend = ctl1_q[C1_SUSPEND];

  // ----------------------------------------------------------------
  // Address match and acknowledge decision
  // ----------------------------------------------------------------
  assign dest = {shift_q[2:0], level};
  assign dest_en = addr_en_q[dest];
  // broadcast always kept; foreign kept without acknowledge
  assign keep = dest_en || (dest == BROADCAST_ADDR) || ctl1_q[C1_FOREIGN];
  assign pend_any = |pend_q;
  assign want_ack = match_q && (hdr_q || !ctl1_q[C1_ACKDIS]);

  // ----------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CBR_IDLE;
      t_q <= 10'h000;
      bit_q <= 4'h0;
      shift_q <= 10'h000;
      hdr_q <= 1'b0;
      match_q <= 1'b0;
      pend_q <= '0;
      flag_set_q <= '0;
      buf_q <= 10'h000;
      buf_wr_q <= 1'b0;
      ack_start_q <= 1'b0;
    end else begin
      flag_set_q <= '0;
      buf_wr_q <= 1'b0;
      ack_start_q <= 1'b0;
      if (fs_tick && t_q != 10'h3ff) begin
        t_q <= t_q + 10'h001;
      end
      case (state_q)
        CBR_IDLE: begin
          if (fall) begin
            state_q <= CBR_START_LOW;
            t_q <= 10'h000;
          end
        end
        CBR_START_LOW: begin
          if (rise) begin
            state_q <= (t_q >= sr_early && t_q <= sr_late) ? CBR_START_HIGH : CBR_IDLE;
          end else if (t_q > sr_late) begin
            state_q <= CBR_IDLE;
          end
        end
        CBR_START_HIGH: begin
          if (fall) begin
            t_q <= 10'h000;
            if (t_q >= sc_min && t_q <= sc_max) begin
              state_q <= CBR_BIT;
              bit_q <= 4'h0;
              hdr_q <= 1'b1;
              flag_set_q[ST_START] <= 1'b1;
            end else begin
              state_q <= CBR_START_LOW;
            end
          end else if (t_q > sc_max) begin
            state_q <= CBR_IDLE;
          end
        end
        CBR_BIT: begin
          if (fall) begin
            t_q <= 10'h000;
            if (t_q < cyc_min) begin
              // min cycle error is never held back
              flag_set_q <= pend_q | (ST_WIDTH'(1) << ST_MIN);
              pend_q <= '0;
              state_q <= CBR_IDLE;
            end else if (bit_q == LAST_BIT) begin
              // drive low, inverted while errors are held
              ack_start_q <= want_ack ^ pend_any;
            end
          end else if (fs_tick && t_q == dec_pt) begin
            shift_q <= {shift_q[8:0], level};
            bit_q <= (bit_q == LAST_BIT) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == DEST_BIT && hdr_q) begin
              match_q <= dest_en && !ctl1_q[C1_FOREIGN];
              if (!keep) begin
                state_q <= CBR_SKIP;
              end
            end
            if (bit_q == EOM_BIT && buf_full_q) begin
              if (suspend) begin
                pend_q[ST_OVR] <= 1'b1;
              end else begin
                flag_set_q <= ST_WIDTH'(1) << ST_OVR;
                state_q <= CBR_IDLE;
              end
            end
            if (bit_q == LAST_BIT) begin
              hdr_q <= 1'b0;
              if (!pend_q[ST_OVR]) begin
                buf_q <= {level, shift_q[0], shift_q[8:1]};
                buf_wr_q <= 1'b1;
              end
              flag_set_q <= pend_q | (ST_WIDTH'(1) << ST_END);
              if (shift_q[0]) begin
                pend_q <= '0;
                state_q <= CBR_IDLE;
              end
            end
          end else if (fs_tick && t_q > cyc_max) begin
            if (suspend) begin
              // wait for more bits up to the timeout
              pend_q[ST_MAX] <= 1'b1;
              if (t_q >= tout) begin
                flag_set_q <= pend_q | (ST_WIDTH'(1) << ST_MAX);
                pend_q <= '0;
                state_q <= CBR_IDLE;
              end
            end else begin
              // low line may be a new start, keep its timing
              flag_set_q <= pend_q | (ST_WIDTH'(1) << ST_MAX);
              pend_q <= '0;
              state_q <= level ? CBR_IDLE : CBR_START_LOW;
            end
          end
        end
        CBR_SKIP: begin
          // Foreign message: ignore until the line stays quiet
          if (fall) begin
            t_q <= 10'h000;
          end else if (t_q > cyc_max) begin
            state_q <= level ? CBR_IDLE : CBR_START_LOW;
          end
        end
        default: begin
          state_q <= CBR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge driver
  // ----------------------------------------------------------------
  // hold low for the acknowledge time
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drive_q <= 1'b0;
      ack_cnt_q <= 7'h00;
    end else if (ack_start_q) begin
      drive_q <= 1'b1;
      ack_cnt_q <= 7'h00;
    end else if (drive_q && fs_tick) begin
      if (ack_cnt_q == ACK_TICKS - 7'h01) begin
        drive_q <= 1'b0;
      end
      ack_cnt_q <= ack_cnt_q + 7'h01;
    end
  end

  // only ever pull low or release
  assign cec_line_out = 1'b0;
  assign cec_line_oe_n = !drive_q;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign acc = hsel && htrans[1] && hready;
  assign rd_stat = acc && !hwrite && (haddr[7:0] == OFS_STATUS);
  assign rd_buf = acc && !hwrite && (haddr[7:0] == OFS_BUFFER);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq_pulse = |flag_set_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_q <= acc && hwrite;
      waddr_q <= haddr[7:0];
      hrdata_q <= 32'h00000000;
      if (acc && !hwrite && haddr[31:8] == 24'h000000) begin
        case (haddr[7:0])
          OFS_CTRL_ONE: hrdata_q <= {12'h000, ctl1_q};
          OFS_CTRL_TWO: hrdata_q <= ctl2_q;
          OFS_ADDR: hrdata_q <= {16'h0000, addr_en_q};
          OFS_STATUS: hrdata_q <= {25'h0000000, stat_q};
          OFS_BUFFER: hrdata_q <= {22'h000000, buf_q};
          default: hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Config is meant to change only while the line is quiet
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl1_q <= C1_RESET;
      ctl2_q <= C2_RESET;
      addr_en_q <= ADDR_RESET;
    end else if (wr_q) begin
      case (waddr_q)
        OFS_CTRL_ONE: ctl1_q <= hwdata[C1_WIDTH-1:0];
        OFS_CTRL_TWO: ctl2_q <= hwdata;
        OFS_ADDR: addr_en_q <= hwdata[15:0];
        default: ctl1_q <= ctl1_q;
      endcase
    end
  end

  // Clear on read, a new event in the same cycle survives
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (rd_stat ? '0 : stat_q) | flag_set_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buf_full_q <= 1'b0;
    end else if (buf_wr_q) begin
      buf_full_q <= 1'b1;
    end else if (rd_buf) begin
      buf_full_q <= 1'b0;
    end
  end

endmodule // cbr_receiver

/* File: dv/cbr_receiver_asserts.sv */
// Port checks for the control line bit receiver
`timescale 1ns/1ns
module cbr_receiver_asserts
  import cbr_pkg::*;
#(
  parameter int FS_DIV = FS_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic cec_line_in,
  input wire logic cec_line_out,
  input wire logic cec_line_oe_n,
  input wire logic irq_pulse
);
  // ----------------------------------------------------------------
  // Length of the current low drive
  // ----------------------------------------------------------------
  logic [15:0] low_cnt_q;
  logic [15:0] low_cnt_d;
  always_comb low_cnt_d = cec_line_oe_n ? 16'h0000 : low_cnt_q + 16'h0001;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_no_read;
    !(hsel && htrans[1] && hready && !hwrite);
  endsequence
  sequence s_ack_hold;
    !cec_line_oe_n [*8];
  endsequence
  property p_ready_high;
    hreadyout == 1'b1;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("hreadyout low");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  // No read, so the data bus falls back to zero
  property p_rdata_idle;
    s_no_read |=> hrdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("hrdata not zero");
  property p_irq_single;
    irq_pulse |=> !irq_pulse;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("irq longer than one cycle");
  property p_line_out;
    cec_line_out == 1'b0;
  endproperty
  a_line_out: assert property (p_line_out) else $error("line driven high");
  property p_ack_after_fall;
    $fell(cec_line_oe_n) |-> !$past(cec_line_in);
  endproperty
  a_ack_after_fall: assert property (p_ack_after_fall) else $error("ack without fall");
  property p_ack_hold;
    $fell(cec_line_oe_n) |-> s_ack_hold;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack low too short");
  // Tick phase lets the low run one tick either way
  property p_ack_length;
    $rose(cec_line_oe_n) |-> int'(low_cnt_q) >= 49 * FS_DIV && int'(low_cnt_q) <= 51 * FS_DIV;
  endproperty
  a_ack_length: assert property (p_ack_length) else $error("ack low length off");
endmodule // cbr_receiver_asserts

/* File: dv/cbr_initiator.sv */
// Behavioural remote initiator on the shared control line
`timescale 1ns/1ns
module cbr_initiator #(
  parameter int FS_DIV = 4
) (
  input wire logic core_clk,
  input wire logic line_in,
  output logic pull
);
  initial pull = 1'b0;
  task automatic tick(input int n);
    repeat (n * FS_DIV) @(posedge core_clk);
  endtask
  task automatic send_start();
    tick(30);
    pull <= 1'b1;
    tick(120);
    pull <= 1'b0;
    tick(28);
  endtask
  task automatic send_bit(input logic b, input int per, output logic seen);
    pull <= 1'b1;
    if (b) begin
      tick(20);
      pull <= 1'b0;
      tick(15);
    end else begin
      tick(35);
    end
    seen = line_in;
    if (!b) begin
      tick(14);
      pull <= 1'b0;
    end
    tick(b ? per - 35 : per - 49);
  endtask
  task automatic send_block(input logic [7:0] d, input logic eom, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], 79, s);
    end
    send_bit(eom, 79, s);
    send_bit(1'b1, 79, ack);
  endtask
endmodule // cbr_initiator

/* File: dv/tb.sv */
// Self-checking bench for the control line bit receiver
`timescale 1ns/1ns
module tb
  import cbr_pkg::*;
;
  localparam int FS_DIV = 4;
  localparam int LIMIT = 80000;
  logic core_clk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic cec_line;
  logic cec_line_out;
  logic cec_line_oe_n;
  logic irq_pulse;
  logic ini_pull;
  logic ack;
  logic [31:0] rd;
  int miscompares;
  int checked;
  int cycles;
  int irq_cnt;
  int irq_mark;
  // Wired low wins, idles high
  assign cec_line = !(ini_pull || !cec_line_oe_n);
  // Interrupt pulses, counted at the quiet clock edge
  always @(negedge core_clk) begin
    if (irq_pulse === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
  cbr_receiver #(.FS_DIV(FS_DIV)) u_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cec_line_in(cec_line),
    .cec_line_out(cec_line_out), .cec_line_oe_n(cec_line_oe_n), .irq_pulse(irq_pulse));
  cbr_initiator #(.FS_DIV(FS_DIV)) u_ini (.core_clk(core_clk), .line_in(cec_line),
    .pull(ini_pull));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single transfer; waits on hready in both phases
  task automatic bus_req(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus_req(a, 1'b0, 32'h00000000);
    chk(what, exp, rd);
  endtask
  task automatic one_msg(input logic [7:0] d, input logic exp_ack, input logic [31:0] exp_st,
    input logic [9:0] exp_buf);
    int n0;
    n0 = irq_cnt;
    u_ini.send_start();
    u_ini.send_block(d, 1'b1, ack);
    chk("ack level", {31'h0, exp_ack}, {31'h0, ack});
    chk("irq count", 32'($countones(exp_st)), 32'(irq_cnt - n0));
    rd_chk("status", OFS_STATUS, exp_st);
    rd_chk("buffer", OFS_BUFFER, {22'h0, exp_buf});
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    miscompares = 0;
    checked = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    // Reset values, last offset unmapped
    for (int a = 0; a < 6; a++) begin
      rd_chk("reset value", 8'(a * 4), 32'h00000000);
    end
    bus_req(OFS_CTRL_TWO, 1'b1, 32'h9c8c7c70);
    bus_req(OFS_ADDR, 1'b1, 32'h00000010);
    bus_req(OFS_CTRL_ONE, 1'b1, 32'h00000072);
    rd_chk("control one", OFS_CTRL_ONE, 32'h00000072);
    u_ini.send_start();
    u_ini.send_block(8'h14, 1'b0, ack);
    chk("header ack", 32'h00000000, {31'h0, ack});
    rd_chk("status", OFS_STATUS, 32'h00000003);
    rd_chk("buffer", OFS_BUFFER, 32'h00000014);
    u_ini.send_block(8'ha5, 1'b1, ack);
    chk("data ack", 32'h00000001, {31'h0, ack});
    rd_chk("status", OFS_STATUS, 32'h00000001);
    rd_chk("buffer", OFS_BUFFER, 32'h000003a5);
    bus_req(OFS_CTRL_ONE, 1'b1, 32'h00000070);
    one_msg(8'h13, 1'b1, 32'h00000002, 10'h3a5);
    one_msg(8'h1f, 1'b1, 32'h00000003, 10'h31f);
    bus_req(OFS_ADDR, 1'b1, 32'h00008010);
    one_msg(8'h2f, 1'b0, 32'h00000003, 10'h12f);
    bus_req(OFS_CTRL_ONE, 1'b1, 32'h00000074);
    one_msg(8'h13, 1'b1, 32'h00000003, 10'h313);
    bus_req(OFS_CTRL_ONE, 1'b1, 32'h00000070);
    u_ini.send_start();
    u_ini.send_bit(1'b1, 55, ack);
    u_ini.send_bit(1'b1, 79, ack);
    rd_chk("status", OFS_STATUS, 32'h0000000a);
    one_msg(8'h24, 1'b0, 32'h00000003, 10'h124);
    // New start without an end block, then overrun on the unread buffer
    u_ini.send_start();
    u_ini.send_block(8'h24, 1'b0, ack);
    chk("header ack", 32'h00000000, {31'h0, ack});
    rd_chk("status", OFS_STATUS, 32'h00000003);
    one_msg(8'h24, 1'b1, 32'h00000026, 10'h024);
    // Held overrun: inverted acknowledge, one interrupt at block end
    bus_req(OFS_CTRL_ONE, 1'b1, 32'h00000071);
    u_ini.send_start();
    u_ini.send_block(8'h24, 1'b0, ack);
    chk("header ack", 32'h00000000, {31'h0, ack});
    rd_chk("status", OFS_STATUS, 32'h00000003);
    irq_mark = irq_cnt;
    u_ini.send_block(8'h5a, 1'b1, ack);
    chk("held irq count", 32'h00000001, 32'(irq_cnt - irq_mark));
    chk("inverted ack", 32'h00000001, {31'h0, ack});
    rd_chk("status", OFS_STATUS, 32'h00000021);
    rd_chk("buffer", OFS_BUFFER, 32'h00000024);
    test_done();
  end
endmodule // tb
bind cbr_receiver cbr_receiver_asserts #(.FS_DIV(FS_DIV)) u_chk (.core_clk(core_clk),
  .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cec_line_in(cec_line_in),
  .cec_line_out(cec_line_out), .cec_line_oe_n(cec_line_oe_n), .irq_pulse(irq_pulse));
